// ---- logic/pdso_cfg.svh ----
// Purpose: Named constants for the pixel digital shift and offset datapath.
// Assumes: Included by its bare name from the design files.
// Notes:   Definitions only.
`ifndef PDSO_CFG_SVH
`define PDSO_CFG_SVH

// ****************************************************************
// Widths and saturation values
// ****************************************************************
`define PDSO_ADC_W      10
`define PDSO_OFS_W      8
`define PDSO_BYTE_W     8
`define PDSO_GAIN_W     32
`define PDSO_SAT10      10'h3FF
`define PDSO_SAT8       8'hFF
`define PDSO_ZERO10     10'h000

// ****************************************************************
// Shift selector codes and offset scaling
// ****************************************************************
`define PDSO_SHIFT_NONE   2'h0
`define PDSO_SHIFT_ONCE   2'h1
`define PDSO_SHIFT_TWICE  2'h2
`define PDSO_SHIFT_SPARE  2'h3
`define PDSO_OFS10_LSB    2
`define PDSO_OFS8_LSB     4
`define PDSO_MSB          9
`define PDSO_MSB_M1       8

// ****************************************************************
// Reference gain readout
// ****************************************************************
`define PDSO_REF_GAIN_DEF 32'h0001_2000
`define PDSO_LAST_BYTE    2'h3
`define PDSO_SIDE_LEFT    1'h0

`endif

// ---- logic/pdso_pkg.sv ----
// Purpose: Shared types of the pixel digital shift and offset datapath.
// Assumes: Nothing beyond the cfg header.
// Notes:   Constants live in pdso_cfg.svh.
`default_nettype none
`include "pdso_cfg.svh"

package pdso_pkg;
  typedef logic [`PDSO_ADC_W-1:0] pdso_pix_t;
  typedef enum logic {PDSO_RD_IDLE, PDSO_RD_SEND} pdso_rd_state_t;
endpackage : pdso_pkg

`default_nettype wire

// ---- logic/pdso_shift.sv ----
// Purpose: One channel of digital shift, saturation and offset.
// Assumes: Settings are stable on the pixel clock.
// Notes:   Purely combinational; the caller registers the result.
`default_nettype none
`include "pdso_cfg.svh"

module pdso_shift
(
  // Sample and settings
  input  wire  logic [`PDSO_ADC_W-1:0] sample,
  input  wire  logic                   mode_8bit,
  input  wire  logic [1:0]             shift_sel,
  input  wire  logic [`PDSO_OFS_W-1:0] offset,
  // Result, eight-bit results sit in the low bits
  output logic       [`PDSO_ADC_W-1:0] result
);

  // ****************************************************************
  // Shift with saturation
  // ****************************************************************
  wire logic                   sat_once;
  wire logic                   sat_twice;
  wire logic [`PDSO_ADC_W-1:0] sh10;
  wire logic [7:0]             sh8;

  assign sat_once  = sample[`PDSO_MSB];
  assign sat_twice = sample[`PDSO_MSB] | sample[`PDSO_MSB_M1];

  // The spare code falls through to no shift so a stray write cannot blank video.
  assign sh10 = (shift_sel == `PDSO_SHIFT_ONCE)  ? (sat_once  ? `PDSO_SAT10 :
                                                   {sample[8:0], 1'b0})  :
                (shift_sel == `PDSO_SHIFT_TWICE) ? (sat_twice ? `PDSO_SAT10 :
                                                   {sample[7:0], 2'b00}) :
                sample;
  assign sh8  = (shift_sel == `PDSO_SHIFT_ONCE)  ? (sat_once  ? `PDSO_SAT8 :
                                                   sample[8:1]) :
                (shift_sel == `PDSO_SHIFT_TWICE) ? (sat_twice ? `PDSO_SAT8 :
                                                   sample[7:0]) :
                sample[9:2];

  // ****************************************************************
  // Offset, added after the shift and clipped at full scale
  // ****************************************************************
  wire logic [`PDSO_ADC_W:0] sum10;
  wire logic [8:0]           sum8;

  assign sum10 = {1'b0, sh10} + {5'h00, offset[7:`PDSO_OFS10_LSB]};
  assign sum8  = {1'b0, sh8} + {5'h00, offset[7:`PDSO_OFS8_LSB]};

  assign result = mode_8bit ? (sum8[8] ? {2'b00, `PDSO_SAT8} : {2'b00, sum8[7:0]})
                            : (sum10[`PDSO_ADC_W] ? `PDSO_SAT10 : sum10[`PDSO_ADC_W-1:0]);

endmodule // pdso_shift

`default_nettype wire

// ---- logic/pdso_top.sv ----
// Purpose: Pixel output datapath: digital shift, saturation, per-side offset
//          and reference gain readout for the left and right converter channels.
// Assumes: Converter samples and settings arrive on the pixel clock.
// Notes:   One cycle from sample to pixel output.
`default_nettype none
`include "pdso_cfg.svh"

module pdso_top
#(
  parameter logic [`PDSO_GAIN_W-1:0] REF_GAIN_LEFT  = `PDSO_REF_GAIN_DEF,
  parameter logic [`PDSO_GAIN_W-1:0] REF_GAIN_RIGHT = `PDSO_REF_GAIN_DEF
)
(
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // Settings
  input  wire logic                   mode_8bit,
  input  wire logic [1:0]             shift_sel,
  input  wire logic [`PDSO_OFS_W-1:0] offset_left,
  input  wire logic [`PDSO_OFS_W-1:0] offset_right,
  // Converter samples
  input  wire logic                   in_valid,
  input  wire logic [`PDSO_ADC_W-1:0] adc_left,
  input  wire logic [`PDSO_ADC_W-1:0] adc_right,
  // Pixel output toward the frame grabber
  output var  logic                   pix_valid_ff,
  output var  logic [`PDSO_ADC_W-1:0] pix_left_ff,
  output var  logic [`PDSO_ADC_W-1:0] pix_right_ff,
  // Reference gain readout
  input  wire logic                   gain_rd_req,
  input  wire logic                   gain_rd_side,
  output var  logic                   gain_busy_ff,
  output var  logic                   gain_byte_valid_ff,
  output var  logic [`PDSO_BYTE_W-1:0] gain_byte_ff
);

  // ****************************************************************
  // Per-side shift and offset
  // ****************************************************************
  wire logic [`PDSO_ADC_W-1:0] samp [2];
  wire logic [`PDSO_OFS_W-1:0] ofs  [2];
  wire logic [`PDSO_ADC_W-1:0] res  [2];

  assign samp[0] = adc_left;
  assign samp[1] = adc_right;
  assign ofs[0]  = offset_left;
  assign ofs[1]  = offset_right;

  // Both sides share one shift setting so the halves of the image stay matched.
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_side
      pdso_shift u_shift
      (
        .sample    (samp[ch]),
        .mode_8bit (mode_8bit),
        .shift_sel (shift_sel),
        .offset    (ofs[ch]),
        .result    (res[ch])
      );
    end
  endgenerate

  // ****************************************************************
  // Output registers
  // ****************************************************************
  // Pixels hold their last value while in_valid is low; the grabber qualifies by valid.
  wire logic [`PDSO_ADC_W-1:0] nxt_pix_left;
  wire logic [`PDSO_ADC_W-1:0] nxt_pix_right;

  assign nxt_pix_left  = in_valid ? res[0] : pix_left_ff;
  assign nxt_pix_right = in_valid ? res[1] : pix_right_ff;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pix_valid_ff <= 1'b0;
      pix_left_ff  <= `PDSO_ZERO10;
      pix_right_ff <= `PDSO_ZERO10;
    end
    else
    begin
      pix_valid_ff <= in_valid;
      pix_left_ff  <= nxt_pix_left;
      pix_right_ff <= nxt_pix_right;
    end
  end

  // ****************************************************************
  // Reference gain readout, fraction bytes first
  // ****************************************************************
  pdso_pkg::pdso_rd_state_t   rd_state_ff;
  pdso_pkg::pdso_rd_state_t   nxt_rd_state;
  logic [1:0]                 byte_idx_ff;
  logic [`PDSO_GAIN_W-1:0]    gain_word_ff;
  wire  logic                 rd_start;
  wire  logic                 rd_last;
  wire  logic [1:0]           nxt_byte_idx;
  wire  logic [`PDSO_GAIN_W-1:0] sel_gain;
  wire  logic [`PDSO_GAIN_W-1:0] nxt_gain_word;

  assign rd_start  = gain_rd_req && (rd_state_ff == pdso_pkg::PDSO_RD_IDLE);
  assign rd_last   = (byte_idx_ff == `PDSO_LAST_BYTE);
  assign sel_gain  = (gain_rd_side == `PDSO_SIDE_LEFT) ? REF_GAIN_LEFT : REF_GAIN_RIGHT;
  assign nxt_byte_idx  = rd_start ? 2'h0 : byte_idx_ff + 2'h1;
  // Word shifts right each byte: 1/65536, 1/256, integer low, integer high.
  assign nxt_gain_word = rd_start ? sel_gain : {8'h00, gain_word_ff[31:8]};

  always_comb
  begin
    nxt_rd_state = rd_state_ff;
    case (rd_state_ff)
      pdso_pkg::PDSO_RD_IDLE:
        if (gain_rd_req)
          nxt_rd_state = pdso_pkg::PDSO_RD_SEND;
      pdso_pkg::PDSO_RD_SEND:
        if (rd_last)
          nxt_rd_state = pdso_pkg::PDSO_RD_IDLE;
      default:
        nxt_rd_state = pdso_pkg::PDSO_RD_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rd_state_ff        <= pdso_pkg::PDSO_RD_IDLE;
      byte_idx_ff        <= 2'h0;
      gain_word_ff       <= 32'h0000_0000;
      gain_busy_ff       <= 1'b0;
      gain_byte_valid_ff <= 1'b0;
      gain_byte_ff       <= 8'h00;
    end
    else
    begin
      rd_state_ff        <= nxt_rd_state;
      byte_idx_ff        <= nxt_byte_idx;
      gain_word_ff       <= nxt_gain_word;
      gain_busy_ff       <= (nxt_rd_state == pdso_pkg::PDSO_RD_SEND);
      gain_byte_valid_ff <= rd_start || (rd_state_ff == pdso_pkg::PDSO_RD_SEND && !rd_last);
      gain_byte_ff       <= nxt_gain_word[7:0];
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_ten_pass_through: assert property (
    in_valid && !mode_8bit && shift_sel == `PDSO_SHIFT_NONE && offset_left == 8'h00
    |=> pix_left_ff == $past(adc_left)) else $error("ten-bit pass-through wrong");
  a_ten_once_bits: assert property (
    in_valid && !mode_8bit && shift_sel == `PDSO_SHIFT_ONCE && !adc_left[9]
    && offset_left == 8'h00
    |=> pix_left_ff == {$past(adc_left[8:0]), 1'b0}) else $error("shift once bits wrong");
  a_once_saturates: assert property (
    in_valid && !mode_8bit && shift_sel == `PDSO_SHIFT_ONCE && adc_right[9]
    |=> pix_right_ff == `PDSO_SAT10) else $error("shift once did not saturate");
  a_ten_twice_bits: assert property (
    in_valid && !mode_8bit && shift_sel == `PDSO_SHIFT_TWICE && adc_left[9:8] == 2'b00
    && offset_left == 8'h00
    |=> pix_left_ff == {$past(adc_left[7:0]), 2'b00}) else $error("shift twice bits wrong");
  a_twice_saturates: assert property (
    in_valid && !mode_8bit && shift_sel == `PDSO_SHIFT_TWICE && adc_left[9:8] != 2'b00
    |=> pix_left_ff == `PDSO_SAT10) else $error("shift twice did not saturate");
  a_ofs_full_range: assert property (
    in_valid && !mode_8bit && shift_sel == `PDSO_SHIFT_NONE && adc_right == 10'h000
    |=> pix_right_ff == {4'h0, $past(offset_right[7:2])}) else $error("offset range wrong");
  a_ten_offset_step: assert property (
    in_valid && !mode_8bit && shift_sel == `PDSO_SHIFT_NONE && adc_left < 10'h100
    |=> pix_left_ff == $past(adc_left) + {4'h0, $past(offset_left[7:2])})
    else $error("ten-bit offset step wrong");
  a_eight_offset_step: assert property (
    in_valid && mode_8bit && shift_sel == `PDSO_SHIFT_NONE && adc_left < 10'h200
    |=> pix_left_ff == {2'b00, $past(adc_left[9:2])} + {6'h00, $past(offset_left[7:4])})
    else $error("eight-bit offset step wrong");
  a_gain_byte_order: assert property (
    rd_start && gain_rd_side == `PDSO_SIDE_LEFT
    |=> gain_byte_valid_ff && gain_byte_ff == REF_GAIN_LEFT[7:0]
    ##1 gain_byte_valid_ff && gain_byte_ff == REF_GAIN_LEFT[15:8]
    ##1 gain_byte_valid_ff && gain_byte_ff == REF_GAIN_LEFT[23:16]
    ##1 gain_byte_valid_ff && gain_byte_ff == REF_GAIN_LEFT[31:24]
    ##1 !gain_byte_valid_ff) else $error("gain byte order wrong");
  a_busy_with_bytes: assert property (
    gain_byte_valid_ff |-> gain_busy_ff) else $error("busy low while a byte is sent");
  a_eight_none_bits: assert property (
    in_valid && mode_8bit && shift_sel == `PDSO_SHIFT_NONE && offset_right == 8'h00
    |=> pix_right_ff == {2'b00, $past(adc_right[9:2])}) else $error("eight-bit none wrong");
  a_eight_once_bits: assert property (
    in_valid && mode_8bit && shift_sel == `PDSO_SHIFT_ONCE && offset_left == 8'h00
    |=> pix_left_ff == ($past(adc_left[9]) ? 10'h0FF : {2'b00, $past(adc_left[8:1])}))
    else $error("eight-bit once wrong");
  a_eight_twice_bits: assert property (
    in_valid && mode_8bit && shift_sel == `PDSO_SHIFT_TWICE && offset_left == 8'h00
    |=> pix_left_ff == (($past(adc_left[9:8]) != 2'b00) ? 10'h0FF
                        : {2'b00, $past(adc_left[7:0])})) else $error("eight-bit twice wrong");
  a_spare_as_none: assert property (
    in_valid && !mode_8bit && shift_sel == `PDSO_SHIFT_SPARE && offset_right == 8'h00
    |=> pix_right_ff == $past(adc_right)) else $error("spare shift code not none");

  c_once_saturated: cover property (in_valid && shift_sel == `PDSO_SHIFT_ONCE && adc_left[9]);
  c_eight_twice: cover property (in_valid && mode_8bit && shift_sel == `PDSO_SHIFT_TWICE);
  c_gain_right_read: cover property (rd_start && gain_rd_side != `PDSO_SIDE_LEFT);

endmodule // pdso_top

`default_nettype wire

// ---- dv/pdso_grabber.sv ----
// Purpose: Frame grabber model that captures every valid pixel pair.
// Assumes: Pixels are qualified by pix_valid on the rising pixel clock edge.
// Notes:   Keeps only the last pair and a running count for the bench.
`default_nettype none

module pdso_grabber
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Pixel stream from the camera
  input  wire logic        pix_valid,
  input  wire logic [9:0]  pix_left,
  input  wire logic [9:0]  pix_right,
  // Capture results
  output var  logic [15:0] n_pix,
  output var  logic [9:0]  last_left,
  output var  logic [9:0]  last_right
);
  timeunit 1ns;
  timeprecision 100ps;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      n_pix <= 16'h0000;
    end
    else if (pix_valid)
    begin
      n_pix      <= n_pix + 16'h0001;
      last_left  <= pix_left;
      last_right <= pix_right;
    end
  end
endmodule // pdso_grabber

`default_nettype wire

// ---- dv/pixel_digital_shift_offset_tb.sv ----
// Purpose: Self-checking bench for pixel shift, offset and gain readout.
// Assumes: 50 ns pixel clock; synchronous active-high reset.
// Notes:   Expected pixels are computed here; samples exceed safe levels on purpose.
`default_nettype none

module pixel_digital_shift_offset_tb;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [31:0] GAIN_L = 32'h0120_6500;
  localparam logic [31:0] GAIN_R = 32'h0125_D100;

  logic        clk;
  logic        rst;
  logic        mode_8bit;
  logic [1:0]  shift_sel;
  logic [7:0]  offset_left;
  logic [7:0]  offset_right;
  logic        in_valid;
  logic [9:0]  adc_left;
  logic [9:0]  adc_right;
  logic        pix_valid_ff;
  logic [9:0]  pix_left_ff;
  logic [9:0]  pix_right_ff;
  logic        gain_rd_req;
  logic        gain_rd_side;
  logic        gain_busy_ff;
  logic        gain_byte_valid_ff;
  logic [7:0]  gain_byte_ff;
  logic [15:0] n_pix;
  logic [9:0]  seen_left;
  logic [9:0]  seen_right;
  int          miscompares;
  int          n_checks;
  int          sent;
  // Samples cross the 512 and 256 limits so that saturation is exercised.
  logic [9:0]  samples [8] = '{10'h3FF, 10'h200, 10'h1FF, 10'h100,
                                10'h0FF, 10'h155, 10'h000, 10'h2AA};
  logic [7:0]  offsets [8] = '{8'h00, 8'hFF, 8'h04, 8'h10, 8'h03, 8'h0F, 8'h80, 8'h43};

  pdso_top #(.REF_GAIN_LEFT(GAIN_L), .REF_GAIN_RIGHT(GAIN_R)) DUT (
    .clk(clk), .rst(rst), .mode_8bit(mode_8bit), .shift_sel(shift_sel),
    .offset_left(offset_left), .offset_right(offset_right), .in_valid(in_valid),
    .adc_left(adc_left), .adc_right(adc_right), .pix_valid_ff(pix_valid_ff),
    .pix_left_ff(pix_left_ff), .pix_right_ff(pix_right_ff), .gain_rd_req(gain_rd_req),
    .gain_rd_side(gain_rd_side), .gain_busy_ff(gain_busy_ff),
    .gain_byte_valid_ff(gain_byte_valid_ff), .gain_byte_ff(gain_byte_ff));

  pdso_grabber u_grabber (
    .clk(clk), .rst(rst), .pix_valid(pix_valid_ff), .pix_left(pix_left_ff),
    .pix_right(pix_right_ff), .n_pix(n_pix), .last_left(seen_left), .last_right(seen_right));

  // ****************************************************************
  // Clock, comparison and verdict
  // ****************************************************************
  initial
  begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    if (miscompares == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Shift with saturation, then add the scaled offset and clip at full scale.
  function automatic logic [9:0] exp_pix(input logic [9:0] x, input logic m8,
                                         input logic [1:0] sh, input logic [7:0] o);
    logic [10:0] s;
    case (sh)
      2'h1: s = m8 ? (x[9] ? 11'h0FF : {3'h0, x[8:1]}) : (x[9] ? 11'h3FF : {1'h0, x[8:0], 1'h0});
      2'h2: s = m8 ? ((x[9] | x[8]) ? 11'h0FF : {3'h0, x[7:0]})
                   : ((x[9] | x[8]) ? 11'h3FF : {1'h0, x[7:0], 2'h0});
      default: s = m8 ? {3'h0, x[9:2]} : {1'h0, x};
    endcase
    s = s + (m8 ? {7'h00, o[7:4]} : {5'h00, o[7:2]});
    if (m8 && s > 11'h0FF)
      s = 11'h0FF;
    if (!m8 && s > 11'h3FF)
      s = 11'h3FF;
    return s[9:0];
  endfunction

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic px(input logic [9:0] l, input logic [9:0] r, input logic [7:0] ol,
                    input logic [7:0] orr);
    in_valid = 1'h1;
    adc_left = l;
    adc_right = r;
    offset_left = ol;
    offset_right = orr;
    @(posedge clk);
    #1;
    sent++;
    check(32'(pix_valid_ff), 32'h1);
    check(32'(pix_left_ff), 32'(exp_pix(l, mode_8bit, shift_sel, ol)));
    check(32'(pix_right_ff), 32'(exp_pix(r, mode_8bit, shift_sel, orr)));
  endtask

  // A second request is raised mid-burst; it must be ignored.
  task automatic rd(input logic side, input logic [31:0] g);
    gain_rd_req = 1'h1;
    gain_rd_side = side;
    @(posedge clk);
    #1;
    for (int i = 0; i < 4; i++)
    begin
      check(32'(gain_byte_valid_ff), 32'h1);
      check(32'(gain_byte_ff), 32'(g[8*i +: 8]));
      check(32'(gain_busy_ff), 32'h1);
      gain_rd_req = (i == 1);
      @(posedge clk);
      #1;
    end
    check(32'(gain_byte_valid_ff), 32'h0);
    check(32'(gain_busy_ff), 32'h0);
  endtask

  // ****************************************************************
  // Test sequence and watchdog
  // ****************************************************************
  initial
  begin
    rst = 1'h1;
    mode_8bit = 1'h0;
    shift_sel = 2'h0;
    offset_left = 8'h00;
    offset_right = 8'h00;
    in_valid = 1'h0;
    adc_left = 10'h000;
    adc_right = 10'h000;
    gain_rd_req = 1'h0;
    gain_rd_side = 1'h0;
    miscompares = 0;
    n_checks = 0;
    sent = 0;
    repeat (4) @(posedge clk);
    #1;
    check(32'(pix_valid_ff), 32'h0);
    check(32'(pix_left_ff), 32'h0);
    check(32'(gain_byte_valid_ff), 32'h0);
    rst = 1'h0;
    for (int m = 0; m < 2; m++)
      for (int s = 0; s < 4; s++)
        for (int i = 0; i < 8; i++)
        begin
          mode_8bit = m[0];
          shift_sel = s[1:0];
          px(samples[i], ~samples[i], offsets[i], offsets[7-i]);
        end
    in_valid = 1'h0;
    @(posedge clk);
    #1;
    check(32'(pix_valid_ff), 32'h0);
    check(32'(pix_left_ff), 32'(exp_pix(samples[7], 1'h1, 2'h3, offsets[7])));
    check(32'(seen_left), 32'(exp_pix(samples[7], 1'h1, 2'h3, offsets[7])));
    check(32'(n_pix), 32'(sent));
    rd(1'h0, GAIN_L);
    rd(1'h1, GAIN_R);
    final_report();
  end

  initial
  begin
    #(2000 * 50);
    miscompares++;
    final_report();
  end
endmodule // pixel_digital_shift_offset_tb

`default_nettype wire
